// ---- core/dsw_pkg.sv ----
// constants for the drive status and warning word bank
package dsw_pkg;
  // parameter addresses of the readable words
  localparam logic [15:0] ADDR_ACTION_WORD = 16'h1c08;
  localparam logic [15:0] ADDR_LAST_STOP_FAULT = 16'h1c0a;
  localparam logic [15:0] ADDR_ACTIVE_WARNING = 16'h1c16;
  localparam logic [15:0] ADDR_LATCHED_WARNING = 16'h1c18;
  // reset values
  localparam logic [15:0] RESET_ACTION_WORD = 16'h0000;
  localparam logic [15:0] RESET_LAST_STOP_FAULT = 16'h0000;
  localparam logic [15:0] RESET_WARNING_WORD = 16'h0000;
  // warning word bit positions
  localparam int WARN_GENERAL = 0;
  localparam int WARN_STAGE_TEMP = 1;
  localparam int WARN_MOTOR_TEMP = 2;
  localparam int WARN_STAGE_I2T = 4;
  localparam int WARN_MOTOR_I2T = 5;
  localparam int WARN_BRAKE_I2T = 6;
  localparam int WARN_CAN = 7;
  localparam int WARN_ENCODER = 8;
  localparam int WARN_RS485 = 9;
  localparam int WARN_SAFE_TORQUE = 10;
  localparam int WARN_DC_BUS = 11;
  localparam int WARN_PROFIBUS = 12;
  localparam int WARN_POS_INVALID = 13;
  localparam int WARN_ETHERNET = 14;
  // bits that follow their condition instead of latching
  localparam logic [15:0] WARN_SELF_CLEAR_MASK = 16'h2c00;
  // bits fed from the external monitoring sources
  localparam logic [15:0] WARN_SOURCE_MASK = 16'h53f7;
  // action word bit positions
  localparam int ACT_WARNING = 0;
  localparam int ACT_ERR_CLASS_LO = 1;
  localparam int ACT_STANDSTILL = 6;
  localparam int ACT_CLOCKWISE = 7;
  localparam int ACT_COUNTER_CW = 8;
  localparam int ACT_PROFILE_LO = 11;
  // standstill threshold in revolutions per minute
  localparam logic [15:0] STANDSTILL_RPM = 16'h0009;
  // profile generator phases
  typedef enum logic [1:0] {
    DSW_PROF_IDLE,
    DSW_PROF_DECEL,
    DSW_PROF_ACCEL,
    DSW_PROF_CONST
  } dsw_profile_t;
endpackage

// ---- core/dsw_status_words.sv ----
// drive status and warning word bank with parameter read port
module dsw_status_words (
  // clock, reset and freeze of all state
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // monitoring sources, same clock domain, one bit per warning position
  input wire logic [15:0] warning_sources_in,
  // safe torque off pins, active low, asynchronous
  input wire logic safe_torque_off_input_a_n_in,
  input wire logic safe_torque_off_input_b_n_in,
  // supply and position conditions, levels on the same clock
  input wire logic dc_bus_undervoltage_in,
  input wire logic mains_phase_missing_in,
  input wire logic position_capture_busy_in,
  // fault reset pulse from the command decoder
  input wire logic fault_clear_command_in,
  // error classes, signed speed and profile phase from the motion core
  input wire logic [3:0] error_class_active_in,
  input wire logic signed [15:0] motor_speed_rpm_in,
  input wire logic [1:0] profile_phase_in,
  // stop fault report, number valid with its strobe
  input wire logic stop_fault_valid_in,
  input wire logic [15:0] stop_fault_number_in,
  // parameter read port
  // one request per cycle, answered one edge later
  input wire logic param_read_in,
  input wire logic [15:0] param_addr_in,
  output logic [15:0] param_data_out,
  output logic param_valid_out,
  output logic param_error_out
);
  // all block state in one record
  // one record keeps reset and freeze handling in a single place,
  // so no field can be forgotten when the clock enable is low
  typedef struct packed {
    logic [15:0] active_warning; // unlatched warnings
    logic [15:0] latched_warning; // saved warnings
    logic [15:0] action_word; // action status
    logic [15:0] last_stop_fault; // number of last stop fault
    logic [15:0] read_data; // read answer data
    logic read_valid; // read answer strobe
    logic read_error; // unmapped address strobe
  } dsw_state_t;

  dsw_state_t state_reg;
  dsw_state_t state_next;

  // helpers: synchroniser output, then words rebuilt every cycle
  logic [1:0] sto_sync; // synchronised safe torque pins, active low
  logic [15:0] warn_now; // warnings active this cycle
  logic [15:0] action_now; // action word this cycle
  logic [15:0] speed_mag; // speed magnitude

  // safe torque off pins come from outside and are synchronised first
  // hazard: an unsynchronised pin could reach the latch half-settled;
  // the stages reset to the inactive level so no warning follows reset
  // both pins share one synchroniser so they move together
  dsw_sync2 #(
    .WIDTH(2),
    .RESET_VALUE(2'h3)
  ) u_sto_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .async_in({safe_torque_off_input_b_n_in, safe_torque_off_input_a_n_in}),
    .sync_out(sto_sync)
  );

  // build the current warning and action words
  // words are built from this cycle's inputs and the synchronised safe torque pins
  always_comb begin
    // external sources only at their own positions, reserved bits zero
    // reserved 3 and 15 and the three locally raised bits are masked
    warn_now = warning_sources_in & dsw_pkg::WARN_SOURCE_MASK;
    // the three conditions raised here rather than by the sources
    warn_now[dsw_pkg::WARN_SAFE_TORQUE] = ~sto_sync[0] | ~sto_sync[1];
    warn_now[dsw_pkg::WARN_DC_BUS] = dc_bus_undervoltage_in | mains_phase_missing_in;
    warn_now[dsw_pkg::WARN_POS_INVALID] = position_capture_busy_in;
    // magnitude of the signed speed
    // hazard: the most negative speed has no positive twin; the cast keeps
    // it as 16'h8000, which still lies far above the standstill limit
    // and so never reads as standstill
    if (motor_speed_rpm_in < 0) begin
      speed_mag = 16'(-motor_speed_rpm_in);
    end else begin
      speed_mag = 16'(motor_speed_rpm_in);
    end
    // reserved action bits stay zero
    action_now = 16'h0000;
    action_now[dsw_pkg::ACT_WARNING] = |warn_now;
    action_now[dsw_pkg::ACT_ERR_CLASS_LO +: 4] = error_class_active_in;
    action_now[dsw_pkg::ACT_STANDSTILL] = speed_mag < dsw_pkg::STANDSTILL_RPM;
    // either direction bit may show together with standstill at low speed
    action_now[dsw_pkg::ACT_CLOCKWISE] = motor_speed_rpm_in > 0;
    action_now[dsw_pkg::ACT_COUNTER_CW] = motor_speed_rpm_in < 0;
    // one-hot profile phase in bits 11 to 14
    // the cast lets the case name the phases; all four codes are used
    case (dsw_pkg::dsw_profile_t'(profile_phase_in))
      dsw_pkg::DSW_PROF_IDLE: begin
        // reference speed is zero
        action_now[dsw_pkg::ACT_PROFILE_LO] = 1'b1;
      end
      dsw_pkg::DSW_PROF_DECEL: begin
        // speed falling toward the target
        action_now[dsw_pkg::ACT_PROFILE_LO + 1] = 1'b1;
      end
      dsw_pkg::DSW_PROF_ACCEL: begin
        // speed rising toward the target
        action_now[dsw_pkg::ACT_PROFILE_LO + 2] = 1'b1;
      end
      dsw_pkg::DSW_PROF_CONST: begin
        // running at the target speed
        action_now[dsw_pkg::ACT_PROFILE_LO + 3] = 1'b1;
      end
      default: begin
        // unreachable with a two-bit phase, leaves the field clear
        action_now[dsw_pkg::ACT_PROFILE_LO] = 1'b0;
      end
    endcase
  end

  // next state: words, latching, read answers
  // read answers are registered one edge after the request
  always_comb begin
    state_next = state_reg;
    // a low clock enable leaves every word and answer frozen
    if (ce_in) begin
      state_next.active_warning = warn_now;
      state_next.action_word = action_now;
      // fault clear empties the latch, a new warning in that cycle still sets
      // hazard: a warning that arises in the clear cycle must not be lost
      if (fault_clear_command_in) begin
        state_next.latched_warning = warn_now;
      end else begin
        // no clear: new warnings add to what is held
        state_next.latched_warning = state_reg.latched_warning | warn_now;
      end
      // self-clearing bits just follow their condition
      // these three report a present condition and would mislead
      // if they stayed set after it was gone
      state_next.latched_warning = (state_next.latched_warning
        & ~dsw_pkg::WARN_SELF_CLEAR_MASK) | (warn_now & dsw_pkg::WARN_SELF_CLEAR_MASK);
      // remember the most recent stop fault
      // without a new report the old number stands
      if (stop_fault_valid_in) begin
        state_next.last_stop_fault = stop_fault_number_in;
      end
      // answer a read one cycle later
      // the answer carries the word as held before this edge, so a read
      // sees inputs taken at least one edge earlier
      // strobes drop at the next enabled edge unless another read comes
      state_next.read_valid = 1'b0;
      state_next.read_error = 1'b0;
      if (param_read_in) begin
        state_next.read_valid = 1'b1;
        // only the four mapped words return data, other addresses answer with an error
        case (param_addr_in)
          dsw_pkg::ADDR_ACTION_WORD: begin
            // status of motion and error classes
            state_next.read_data = state_reg.action_word;
          end
          dsw_pkg::ADDR_LAST_STOP_FAULT: begin
            // number of the fault that last stopped the drive
            state_next.read_data = state_reg.last_stop_fault;
          end
          dsw_pkg::ADDR_ACTIVE_WARNING: begin
            // warnings present now, not latched
            state_next.read_data = state_reg.active_warning;
          end
          dsw_pkg::ADDR_LATCHED_WARNING: begin
            // warnings seen since the last clear
            state_next.read_data = state_reg.latched_warning;
          end
          default: begin
            // unmapped address reads zero and flags an error
            state_next.read_data = 16'h0000;
            state_next.read_error = 1'b1;
          end
        endcase
      end
    end
  end

  // register the state
  // asynchronous reset loads constants only, field by field,
  // so the warning, action and stop fault reset values come from the package
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg.active_warning <= dsw_pkg::RESET_WARNING_WORD;
      state_reg.latched_warning <= dsw_pkg::RESET_WARNING_WORD;
      state_reg.action_word <= dsw_pkg::RESET_ACTION_WORD;
      state_reg.last_stop_fault <= dsw_pkg::RESET_LAST_STOP_FAULT;
      state_reg.read_data <= 16'h0000;
      state_reg.read_valid <= 1'b0;
      state_reg.read_error <= 1'b0;
    end else begin
      // the whole record moves at once
      state_reg <= state_next;
    end
  end

  // outputs straight from flip-flops
  // no logic between the registers and the pins
  assign param_data_out = state_reg.read_data;
  assign param_valid_out = state_reg.read_valid;
  assign param_error_out = state_reg.read_error;
endmodule

// ---- core/dsw_sync2.sv ----
// two flip-flop synchroniser for a group of pin levels
module dsw_sync2 #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // both stages held in one state record
  typedef struct packed {
    logic [WIDTH-1:0] meta; // first stage, read only by the second
    logic [WIDTH-1:0] safe; // second stage, safe to use
  } dsw_sync_state_t;

  dsw_sync_state_t state_reg;
  dsw_sync_state_t state_next;

  // shift the pin levels through both stages
  always_comb begin
    state_next = state_reg;
    if (ce_in) begin
      state_next.meta = async_in;
      state_next.safe = state_reg.meta;
    end
  end

  // register the stages
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= {RESET_VALUE, RESET_VALUE};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.safe;
endmodule

// ---- testbench/dsw_bus_master.sv ----
// fieldbus master model that issues parameter reads
module dsw_bus_master (
  input wire logic clk_in,
  input wire logic [15:0] param_data_in,
  input wire logic param_valid_in,
  input wire logic param_error_in,
  output logic param_read_out,
  output logic [15:0] param_addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    param_read_out = 1'b0;
    param_addr_out = 16'h0000;
  end
  // one read: request for one edge, answer taken once it settles
  task automatic read_word(input logic [15:0] a, output logic [17:0] ans);
    @(posedge clk_in);
    param_read_out <= 1'b1;
    param_addr_out <= a;
    @(posedge clk_in);
    param_read_out <= 1'b0;
    // released address shows no stale value
    param_addr_out <= ~a;
    #1 ans = {param_valid_in, param_error_in, param_data_in};
  endtask
endmodule

// ---- testbench/dsw_status_words_sva.sv ----
// assertions on the status word read port
module dsw_chk (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [3:0] error_class_active_in,
  input wire logic stop_fault_valid_in,
  input wire logic [15:0] stop_fault_number_in,
  input wire logic param_read_in,
  input wire logic [15:0] param_addr_in,
  input wire logic [15:0] param_data_out,
  input wire logic param_valid_out,
  input wire logic param_error_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // read taken, and which word it names
  wire logic rd = ce_in && param_read_in;
  wire logic act = rd && param_addr_in == dsw_pkg::ADDR_ACTION_WORD;
  wire logic warn = rd && param_addr_in inside {dsw_pkg::ADDR_LATCHED_WARNING,
    dsw_pkg::ADDR_ACTIVE_WARNING};
  wire logic ok = warn || act || rd && param_addr_in == dsw_pkg::ADDR_LAST_STOP_FAULT;
  // action word read one edge after its inputs were taken
  sequence s_class_read;
    ce_in ##1 act;
  endsequence
  // stop fault reported, then its word read
  sequence s_stop_read;
    ce_in && stop_fault_valid_in ##1 rd && param_addr_in == dsw_pkg::ADDR_LAST_STOP_FAULT;
  endsequence
  a_read_answered: assert property (rd |=> param_valid_out)
    else $error("read not answered");
  // with the enable low the previous answer is frozen, not a new one
  a_no_spurious: assert property (ce_in && !param_read_in |=>
    !param_valid_out && !param_error_out)
    else $error("answer without read");
  a_bad_addr: assert property (rd && !ok |=> param_error_out && param_data_out == 16'h0000)
    else $error("unmapped read not refused");
  a_good_addr: assert property (ok |=> !param_error_out)
    else $error("mapped read refused");
  a_warn_reserved: assert property (warn |=> !param_data_out[3] && !param_data_out[15])
    else $error("warning reserved bit set");
  a_act_reserved: assert property (act |=> (param_data_out & 16'h8620) == 16'h0000)
    else $error("action reserved bit set");
  a_phase_onehot: assert property (act |=> $onehot(param_data_out[14:11]))
    else $error("profile phase not one-hot");
  a_class_bits: assert property (s_class_read |=>
    param_data_out[4:1] == $past(error_class_active_in, 2)) else $error("error class wrong");
  a_stop_number: assert property (s_stop_read |=>
    param_data_out == $past(stop_fault_number_in, 2)) else $error("stop fault wrong");
endmodule

bind dsw_status_words dsw_chk u_chk (.clk_in, .reset_n_in, .ce_in, .error_class_active_in,
  .stop_fault_valid_in, .stop_fault_number_in, .param_read_in, .param_addr_in,
  .param_data_out, .param_valid_out, .param_error_out);

// ---- testbench/tb_drive_status_warning_words.sv ----
// self-checking bench for the status word bank
module tb_drive_status_warning_words;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic safe_torque_off_input_a, safe_torque_off_input_b, uv, mains, pos, clr, sv, rd, valid, error;
  logic [15:0] src, snum, addr, data, lat, stop;
  logic signed [15:0] speed;
  logic [3:0] err;
  logic [1:0] phase;
  logic [31:0] seed = 32'h9082de06;
  logic [31:0] r;
  logic [17:0] ans;
  logic [15:0] held;
  logic ce = 1'b1;
  int fail_count = 0;
  int comparisons = 0;
  // speeds at the standstill edge
  logic [15:0] corner [5] = '{16'h0009, 16'hfff7, 16'h0008, 16'hfff8, 16'h0000};
  dsw_status_words DUT (.clk_in, .reset_n_in, .ce_in(ce), .warning_sources_in(src),
    .safe_torque_off_input_a_n_in(safe_torque_off_input_a), .safe_torque_off_input_b_n_in(safe_torque_off_input_b),
    .dc_bus_undervoltage_in(uv), .mains_phase_missing_in(mains),
    .position_capture_busy_in(pos), .fault_clear_command_in(clr),
    .error_class_active_in(err), .motor_speed_rpm_in(speed), .profile_phase_in(phase),
    .stop_fault_valid_in(sv), .stop_fault_number_in(snum), .param_read_in(rd),
    .param_addr_in(addr), .param_data_out(data), .param_valid_out(valid),
    .param_error_out(error));
  dsw_bus_master u_master (.clk_in, .param_data_in(data), .param_valid_in(valid),
    .param_error_in(error), .param_read_out(rd), .param_addr_out(addr));
  // 25 MHz clock
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // current warnings from the inputs
  function automatic logic [15:0] exp_active();
    return (src & dsw_pkg::WARN_SOURCE_MASK) | {2'b00, pos, 1'b0, uv | mains, !safe_torque_off_input_a || !safe_torque_off_input_b,
      10'h000};
  endfunction
  // action word from the inputs
  function automatic logic [15:0] exp_action();
    logic [15:0] w;
    w = 16'h0000;
    w[0] = |exp_active();
    w[4:1] = err;
    w[6] = speed < 9 && speed > -9;
    w[7] = speed > 0;
    w[8] = speed < 0;
    w[11 + phase] = 1'b1;
    return w;
  endfunction
  // read one word and compare valid, error and data
  task automatic check(input logic [15:0] a, input logic [17:0] e);
    u_master.read_word(a, ans);
    comparisons++;
    if (ans !== e) begin
      fail_count++;
      $display("wrong value at %0t: addr %h got %h exp %h", $time, a, ans, e);
    end
    held = e[15:0];
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  // main sequence
  initial begin
    {src, uv, mains, pos, clr, sv, snum, err, phase, speed, lat, stop} = '0;
    {safe_torque_off_input_a, safe_torque_off_input_b} = 2'b11;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    check(dsw_pkg::ADDR_LAST_STOP_FAULT, {2'b10, dsw_pkg::RESET_LAST_STOP_FAULT});
    check(dsw_pkg::ADDR_LATCHED_WARNING, {2'b10, dsw_pkg::RESET_WARNING_WORD});
    check(16'h1c0c, {2'b11, 16'h0000});
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_in);
      r = rnd();
      src <= r[15:0];
      {safe_torque_off_input_a, safe_torque_off_input_b, pos, clr, sv} <= r[20:16];
      uv <= r[21] & r[22];
      mains <= r[23] & r[24];
      err <= r[28:25];
      phase <= r[30:29];
      r = rnd();
      snum <= r[31:16];
      speed <= i < 5 ? corner[i] : {{11{r[4]}}, r[4:0]};
      @(posedge clk_in);
      // latched model: clear takes current, else self-clear bits follow
      lat = clr ? exp_active() : (lat & ~dsw_pkg::WARN_SELF_CLEAR_MASK) | exp_active();
      stop = sv ? snum : stop;
      {clr, sv} <= 2'b00;
      repeat (3) @(posedge clk_in);
      check(dsw_pkg::ADDR_ACTIVE_WARNING, {2'b10, exp_active()});
      check(dsw_pkg::ADDR_ACTION_WORD, {2'b10, exp_action()});
      check(dsw_pkg::ADDR_LATCHED_WARNING, {2'b10, lat});
      check(dsw_pkg::ADDR_LAST_STOP_FAULT, {2'b10, stop});
      $display("test %0d done", i);
    end
    // freeze: a read is ignored and the data output holds while enable is low
    @(posedge clk_in);
    ce <= 1'b0;
    src <= src ^ 16'h4001;
    check(dsw_pkg::ADDR_ACTION_WORD, {2'b00, held});
    @(posedge clk_in);
    ce <= 1'b1;
    check(dsw_pkg::ADDR_ACTIVE_WARNING, {2'b10, exp_active()});
    $display("test freeze done");
    // stop fault read in the cycle right after its report
    @(posedge clk_in);
    sv <= 1'b1;
    snum <= 16'h5a3c;
    check(dsw_pkg::ADDR_LAST_STOP_FAULT, {2'b10, 16'h5a3c});
    @(posedge clk_in);
    sv <= 1'b0;
    $display("test stop done");
    complete_run();
  end
endmodule
